/* include/ccs_pkg.sv */
// shared constants and types for the charge cycle sequencer
package ccs_pkg;
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned CLK_NS         = 25;
    // pulse-trickle period in ms and its cycle count
    localparam int unsigned TRKL_PERIOD_MS = 1000;
    localparam int unsigned TRKL_CYCLES    = TRKL_PERIOD_MS * (CLK_HZ / 1000);
    // default max charge period in ticks of the 1 s base
    localparam int unsigned MTO_TICKS_DEF  = 3600;
    localparam int unsigned MTO_W          = 16;
    localparam int unsigned PW_W           = 8;
    localparam logic [PW_W-1:0] PW_DEF     = 8'h28;
    localparam int unsigned TICK_W         = 26;

    typedef enum logic [2:0] {
        CCS_IDLE,
        CCS_QUAL,
        CCS_COND,
        CCS_FAST_CC,
        CCS_FAST_CV,
        CCS_TOPOFF,
        CCS_MAINT,
        CCS_DONE_LI
    } ccs_state_type;

    // comparator results sensed at the pins
    typedef struct packed {
        logic below_low;   // cell below low_cell_threshold
        logic at_max;      // cell at max_cell_threshold
        logic below_rch;   // cell below recharge_threshold
        logic temp_cold;   // thermistor above cold_limit_threshold
        logic temp_hot;    // thermistor below hot_limit_threshold
        logic taper;       // current under taper threshold
        logic present;     // pack present
        logic sleep;       // sleep request
    } ccs_sense_type;

    // settings caught from the timer-program pin
    typedef struct packed {
        logic [MTO_W-1:0] mto_ticks;
        logic [PW_W-1:0]  pulse_w;  // trickle pulse width in 1/256 s steps
        logic             topoff_en;
    } ccs_prog_type;
endpackage

/* hw/ccs_sync.sv */
// two-flop synchroniser for a bundle of pin levels
module ccs_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

/* hw/ccs_sequencer.sv */
// charge cycle state machine for a multi-chemistry charger
// Notes on behaviour
// - new cycle on power-up, pack insertion, sleep exit, or lithium depletion.
// - a new cycle first qualifies pack voltage and temperature.
// - cell below low threshold means conditioning, pulsing charge switch each second.
// - trickle pulse width comes from the timer-program setting.
// - status lamp toggles at 1 Hz while qualification is pending.
// - leave conditioning only when voltage above low and temperature in range.
// - conditioning has no timeout.
// - reaching max cell voltage early in fast charge means lithium, else nickel.
// - status lamp on (driven low) throughout fast charge.
// - nickel fast charge is current-limited, watching time, temperature, voltage; the code reacts to temp_cold only, temp_hot is ignored.
// - nickel: optional top-off, then maintenance while below max cell voltage.
// - lithium at max cell voltage switches to taper-current termination.
// - constant-voltage phase ends on taper current or timer expiry.
// - after lithium ends, recharge below recharge threshold restarts the cycle.
// - no maintenance trickle after lithium termination.
// - fast charge limited to 1 period for nickel, 2 for lithium.
// - charge switch high passes current, low blocks it.
// - status lamp off during top-off and maintenance.
// - cold during fast charge pauses timer and conditions; timer resumes after.
module ccs_sequencer
    import ccs_pkg::*;
#(
    parameter int unsigned TRKL_CYC = TRKL_CYCLES
) (
    input  wire logic                   CLK_I,
    input  wire logic                   SYS_RST_I,
    input  wire ccs_pkg::ccs_sense_type SENSE_I,
    input  wire ccs_pkg::ccs_prog_type  PROG_I,
    output logic                        CHARGE_SWITCH_O,
    output logic                        STATUS_LAMP_N_O,
    output logic                        STATUS_LAMP_OE_O,
    output ccs_pkg::ccs_state_type      STATE_O
);
    import ccs_pkg::*;

    // parameter sanity, refused at elaboration
    if (TRKL_CYC < 512) begin
        $error("trickle period too short");
    end
    if (TRKL_CYC >= (1 << TICK_W)) begin
        $error("trickle period too wide");
    end

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TRKL_CYC - 1);
    localparam logic [TICK_W-1:0] STEP      = TICK_W'(TRKL_CYC / 256);
    localparam logic [TICK_W-1:0] HALF      = TICK_W'(TRKL_CYC / 2);

    ccs_sense_type    sense;
    ccs_sense_type    sense_prev_q;
    ccs_prog_type     prog;
    ccs_prog_type     prog_q;
    ccs_state_type    state_q;
    ccs_state_type    state_d;
    logic [TICK_W-1:0] tick_cnt_q;
    logic              sec_tick;
    logic [MTO_W:0]    timer_q;   // fast charge seconds left, wide for 2 periods
    logic              timer_zero;
    logic              started_q;
    logic              restart;
    logic              was_li_q;

    // pins arrive asynchronously, two flops before use
    ccs_sync #(.W($bits(ccs_sense_type) + $bits(ccs_prog_type))) u_sync (
        .clk_i (CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   ({SENSE_I, PROG_I}),
        .q_o   ({sense, prog})
    );

    // is the pulse counter inside the programmed width
    function automatic logic in_pulse(input logic [TICK_W-1:0] cnt,
                                      input logic [PW_W-1:0] width);
        return cnt < TICK_W'(STEP * TICK_W'(width));
    endfunction

    // free-running one second time base
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            tick_cnt_q <= '0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign sec_tick = (tick_cnt_q == TICK_LAST);

    // previous sense levels for insertion and sleep edges
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sense_prev_q <= '0;
            started_q    <= 1'b0;
        end else begin
            sense_prev_q <= sense;
            started_q    <= 1'b1;
        end
    end

    // cycle start events
    assign restart = !started_q
                   || (sense.present && !sense_prev_q.present)
                   || (!sense.sleep && sense_prev_q.sleep)
                   || (state_q == CCS_DONE_LI && sense.below_rch);

    // program settings are captured at each cycle start
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prog_q <= '{mto_ticks: MTO_W'(MTO_TICKS_DEF), pulse_w: PW_DEF, topoff_en: 1'b0};
        end else if (state_q == CCS_IDLE) begin
            prog_q <= prog;
        end
    end

    assign timer_zero = (timer_q == '0);

    // next state decision
    always_comb begin
        state_d = state_q;
        case (state_q)
            CCS_IDLE: begin
                state_d = CCS_QUAL;
            end
            CCS_QUAL: begin
                if (sense.below_low || sense.temp_cold || sense.temp_hot) begin
                    state_d = CCS_COND;
                end else begin
                    state_d = CCS_FAST_CC;
                end
            end
            CCS_COND: begin
                // no timeout here, only conditions end it
                if (!sense.below_low && !sense.temp_cold && !sense.temp_hot) begin
                    state_d = was_li_q ? CCS_FAST_CV : CCS_FAST_CC;
                end
            end
            CCS_FAST_CC: begin
                if (sense.temp_cold) begin
                    state_d = CCS_COND;
                end else if (sense.at_max) begin
                    state_d = CCS_FAST_CV;
                end else if (timer_zero) begin
                    state_d = prog_q.topoff_en ? CCS_TOPOFF : CCS_MAINT;
                end
            end
            CCS_FAST_CV: begin
                if (sense.temp_cold) begin
                    state_d = CCS_COND;
                end else if (sense.taper || timer_zero) begin
                    state_d = CCS_DONE_LI;
                end
            end
            CCS_TOPOFF: begin
                if (timer_zero || sense.at_max) begin
                    state_d = CCS_MAINT;
                end
            end
            CCS_MAINT: begin
                state_d = CCS_MAINT;
            end
            CCS_DONE_LI: begin
                state_d = CCS_DONE_LI;
            end
            default: begin
                state_d = CCS_IDLE;
            end
        endcase
        if (restart || sense.sleep || !sense.present) begin
            state_d = CCS_IDLE;
        end
    end

    // state register
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q <= CCS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // chemistry flag, set once max cell voltage is seen in fast charge
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            was_li_q <= 1'b0;
        end else if (state_q == CCS_IDLE) begin
            was_li_q <= 1'b0;
        end else if (state_q == CCS_FAST_CC && state_d == CCS_FAST_CV) begin
            was_li_q <= 1'b1;
        end
    end

    // charge timer: paused outside fast charge and top-off, extended for the lithium phase
    // idle may last a single cycle, so load from the live setting that prog_q also takes
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            timer_q <= '0;
        end else if (state_q == CCS_IDLE) begin
            timer_q <= {1'b0, prog.mto_ticks};
        end else if (state_q == CCS_FAST_CC && state_d == CCS_FAST_CV) begin
            timer_q <= timer_q + {1'b0, prog_q.mto_ticks};
        end else if (state_q == CCS_FAST_CC && state_d == CCS_TOPOFF) begin
            timer_q <= {1'b0, prog_q.mto_ticks};
        end else if ((state_q == CCS_FAST_CC || state_q == CCS_FAST_CV
                      || state_q == CCS_TOPOFF) && sec_tick && !timer_zero) begin
            timer_q <= timer_q - 1'b1;
        end
    end

    // charge switch output, high passes current
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            CHARGE_SWITCH_O <= 1'b0;
        end else begin
            case (state_d)
                CCS_FAST_CC, CCS_FAST_CV: begin
                    CHARGE_SWITCH_O <= 1'b1;
                end
                CCS_COND, CCS_MAINT: begin
                    CHARGE_SWITCH_O <= in_pulse(tick_cnt_q, prog_q.pulse_w)
                                       && !(state_d == CCS_MAINT && sense.at_max);
                end
                CCS_TOPOFF: begin
                    CHARGE_SWITCH_O <= in_pulse(tick_cnt_q, PW_W'(8'h10));
                end
                default: begin
                    CHARGE_SWITCH_O <= 1'b0;
                end
            endcase
        end
    end

    // open-drain status lamp: on = pulled low, off = released
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            STATUS_LAMP_OE_O <= 1'b0;
        end else begin
            case (state_d)
                CCS_QUAL, CCS_COND: begin
                    STATUS_LAMP_OE_O <= (tick_cnt_q < HALF);
                end
                CCS_FAST_CC, CCS_FAST_CV: begin
                    STATUS_LAMP_OE_O <= 1'b1;
                end
                default: begin
                    STATUS_LAMP_OE_O <= 1'b0;
                end
            endcase
        end
    end

    // lamp data is always low; the enable decides
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            STATUS_LAMP_N_O <= 1'b0;
            STATE_O         <= CCS_IDLE;
        end else begin
            STATUS_LAMP_N_O <= 1'b0;
            STATE_O         <= state_d;
        end
    end
endmodule

/* sim/ccs_sequencer_asserts.sv */
// assertion checker for the charge cycle sequencer ports
module ccs_sequencer_asserts
    import ccs_pkg::*;
(
    input wire logic                   CLK_I,
    input wire logic                   SYS_RST_I,
    input wire ccs_pkg::ccs_sense_type SENSE_I,
    input wire ccs_pkg::ccs_prog_type  PROG_I,
    input wire logic                   CHARGE_SWITCH_O,
    input wire logic                   STATUS_LAMP_N_O,
    input wire logic                   STATUS_LAMP_OE_O,
    input wire ccs_pkg::ccs_state_type STATE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // pack present and awake
    wire ok = SENSE_I.present && !SENSE_I.sleep;
    // outputs per state
    a_fast_lamp_on: assert property (
        STATE_O inside {CCS_FAST_CC, CCS_FAST_CV} |-> STATUS_LAMP_OE_O)
        else $error("lamp dark in fast charge");
    a_lamp_data_low: assert property (
        STATUS_LAMP_N_O == 1'b0)
        else $error("lamp data not low");
    a_cc_switch_on: assert property (
        STATE_O == CCS_FAST_CC |-> CHARGE_SWITCH_O)
        else $error("switch low in fast charge");
    a_maint_lamp_off: assert property (
        STATE_O inside {CCS_TOPOFF, CCS_MAINT} |-> !STATUS_LAMP_OE_O)
        else $error("lamp lit in top-off or maintenance");
    a_done_switch_off: assert property (
        STATE_O == CCS_DONE_LI |-> !CHARGE_SWITCH_O)
        else $error("switch high after lithium end");
    // legal successors and holds
    a_done_next: assert property (
        STATE_O == CCS_DONE_LI |=> STATE_O inside {CCS_DONE_LI, CCS_IDLE})
        else $error("bad state after lithium end");
    a_idle_next: assert property (
        STATE_O == CCS_IDLE |=> STATE_O inside {CCS_IDLE, CCS_QUAL})
        else $error("idle skipped qualification");
    a_cond_hold: assert property (
        (ok && SENSE_I.below_low)[*5] ##0 STATE_O == CCS_COND |=> STATE_O == CCS_COND)
        else $error("conditioning left with low cell");
    a_sleep_idle: assert property (
        SENSE_I.sleep[*5] |-> STATE_O == CCS_IDLE)
        else $error("not idle in sleep");
    a_taper_end: assert property (
        (ok && !SENSE_I.temp_cold && SENSE_I.taper)[*8] |-> STATE_O != CCS_FAST_CV)
        else $error("taper did not end charge");
    a_cold_leaves_fast: assert property (
        SENSE_I.temp_cold[*4] |-> !(STATE_O inside {CCS_FAST_CC, CCS_FAST_CV}))
        else $error("fast charge kept while cold");
endmodule

/* sim/ccs_sequencer_test.sv */
// self-checking bench for the charge cycle sequencer
module ccs_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ccs_pkg::*;
    localparam int TC = 1024;
    logic          clk;
    logic          rst;
    ccs_sense_type sense;
    ccs_prog_type  prog;
    logic          sw;
    logic          lamp_n;
    logic          lamp_oe;
    ccs_state_type st;
    int            n_mismatch = 0;
    int            total_checks = 0;
    logic [31:0]   lfsr = 32'h215f6348;

    ccs_sequencer #(.TRKL_CYC(TC)) u_dut (.CLK_I(clk), .SYS_RST_I(rst), .SENSE_I(sense),
        .PROG_I(prog), .CHARGE_SWITCH_O(sw), .STATUS_LAMP_N_O(lamp_n),
        .STATUS_LAMP_OE_O(lamp_oe), .STATE_O(st));

    // clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // pseudo-random source
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // compare tasks
    task automatic chk_state(input ccs_state_type e);
        total_checks++;
        if (st !== e) begin
            n_mismatch++;
            $display("ERROR state exp %s got %s", e.name(), st.name());
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic chk_cnt(input string n, input int e, input int g);
        total_checks++;
        if (g != e) begin
            n_mismatch++;
            $display("ERROR %s exp %0d got %0d", n, e, g);
        end
    endtask

    // stimulus and waiting helpers
    task automatic drive(input ccs_sense_type v);
        @(posedge clk);
        sense <= v;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_st(input ccs_state_type e, input int lim);
        for (int i = 0; i < lim && st !== e; i++) @(negedge clk);
        chk_state(e);
    endtask
    task automatic count_period(output int hi, output int lt);
        hi = 0;
        lt = 0;
        repeat (TC) begin
            @(negedge clk);
            hi += (sw === 1'b1);
            lt += (lamp_oe === 1'b1);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    // main sequence; sense bits: low,max,rch,cold,hot,taper,present,sleep
    initial begin
        int hi;
        int lt;
        int pw;
        rst = 1'b1;
        sense = 8'h02;
        prog = '{mto_ticks: 16'h0002, pulse_w: 8'h10, topoff_en: 1'b1};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // nickel: fast, timeout, top-off, maintenance
        wait_st(CCS_FAST_CC, 20);
        chk_bit("switch", 1'b1, sw);
        chk_bit("lamp", 1'b1, lamp_oe);
        chk_bit("lamp data", 1'b0, lamp_n);
        cyc(TC - 8);
        chk_state(CCS_FAST_CC);
        wait_st(CCS_TOPOFF, 2 * TC);
        count_period(hi, lt);
        chk_cnt("topoff pulse", TC / 16, hi);
        chk_cnt("topoff lamp", 0, lt);
        wait_st(CCS_MAINT, 3 * TC);
        // sleep, then conditioning with a random pulse width
        drive(8'h03);
        wait_st(CCS_IDLE, 10);
        lfsr = nxt(lfsr);
        pw = 8 + int'(lfsr[4:0]);
        @(posedge clk);
        prog <= '{mto_ticks: 16'h0004, pulse_w: 8'(pw), topoff_en: 1'b0};
        cyc(4);
        drive(8'h82);
        wait_st(CCS_COND, 20);
        cyc(4);
        count_period(hi, lt);
        chk_cnt("trickle pulse", pw * (TC / 256), hi);
        chk_cnt("blink", TC / 2, lt);
        cyc(2 * TC);
        chk_state(CCS_COND);
        drive(8'h12);
        cyc(20);
        chk_state(CCS_COND);
        drive(8'h02);
        wait_st(CCS_FAST_CC, 20);
        // cold in fast charge pauses the timer
        drive(8'h12);
        wait_st(CCS_COND, 10);
        cyc(3 * TC);
        drive(8'h02);
        wait_st(CCS_FAST_CC, 10);
        cyc(TC / 2);
        chk_state(CCS_FAST_CC);
        // lithium: taper end, recharge, timer end
        drive(8'h42);
        wait_st(CCS_FAST_CV, 10);
        drive(8'h46);
        wait_st(CCS_DONE_LI, 10);
        @(posedge clk);
        prog <= '{mto_ticks: 16'h0002, pulse_w: 8'h10, topoff_en: 1'b0};
        cyc(20);
        drive(8'h22);
        wait_st(CCS_FAST_CC, 30);
        drive(8'h42);
        wait_st(CCS_FAST_CV, 10);
        cyc(TC);
        chk_state(CCS_FAST_CV);
        wait_st(CCS_DONE_LI, 4 * TC);
        chk_bit("switch", 1'b0, sw);
        cyc(TC);
        chk_state(CCS_DONE_LI);
        // pack removal and replacement
        drive(8'h00);
        wait_st(CCS_IDLE, 10);
        drive(8'h02);
        wait_st(CCS_FAST_CC, 30);
        conclude();
    end
endmodule

// checker attached to the sequencer
bind ccs_sequencer ccs_sequencer_asserts u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .SENSE_I(SENSE_I), .PROG_I(PROG_I), .CHARGE_SWITCH_O(CHARGE_SWITCH_O),
    .STATUS_LAMP_N_O(STATUS_LAMP_N_O), .STATUS_LAMP_OE_O(STATUS_LAMP_OE_O),
    .STATE_O(STATE_O));
